// ### sdc_pkg.sv
// Package: register map, fields, modes and states of the sigma-delta converter control
package sdc_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_MODE = 8'h00;
  localparam logic [7:0] ADDR_CFG = 8'h04;
  localparam logic [7:0] ADDR_CTRL = 8'h08;
  localparam logic [7:0] ADDR_BUF = 8'h0C;
  localparam logic [7:0] ADDR_CLKDIV = 8'h10;
  localparam logic [7:0] ADDR_DECH = 8'h14;
  localparam logic [7:0] ADDR_DECL = 8'h18;
  localparam logic [7:0] ADDR_OFFSET = 8'h1C;
  localparam logic [7:0] ADDR_GAIN = 8'h20;
  localparam logic [7:0] ADDR_RESULT = 8'h24;
  // Field positions
  localparam int MODE_EN_BIT = 0;
  localparam int MODE_SM_LSB = 4;
  localparam int CFG_REF_BIT = 0;
  localparam int CTRL_GAIN_LSB = 0;
  localparam int CTRL_DIFF_BIT = 3;
  localparam int CTRL_BUSY_BIT = 4;
  localparam int CTRL_DONE_BIT = 5;
  localparam int CTRL_ERR_BIT = 6;
  localparam int BUF_POS_LSB = 0;
  localparam int BUF_NEG_LSB = 2;
  // Reset values
  localparam logic [7:0] CLKDIV_RST = 8'h00;
  localparam logic [10:0] DECIMATION_FIELD_RST = 11'h0_13F;
  localparam logic [23:0] OFFSET_RST = 24'h00_0000;
  localparam logic [23:0] GAIN_RST = 24'h80_0000;
  // Error limits
  localparam logic [23:0] FS_POS = 24'h7F_FFFF;
  localparam logic [23:0] FS_NEG = 24'h80_0000;
  localparam logic [23:0] GAIN_MAX = 24'hFF_FFFF;
  // Timing
  localparam logic [6:0] SAMPLE_DIV_LAST = 7'h7F;
  localparam int GAIN_FRAC = 23;
  // System mode encodings
  typedef enum logic [2:0] {
    SM_IDLE = 3'h0,
    SM_CONV = 3'h1,
    SM_INT_FULL = 3'h3,
    SM_INT_OFF = 3'h4,
    SM_INT_GAIN = 3'h5,
    SM_SYS_OFF = 3'h6,
    SM_SYS_GAIN = 3'h7
  } sdc_mode_t;
  // Sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CONV = 2'b01,
    ST_OFF = 2'b11,
    ST_GAIN = 2'b10
  } sdc_state_t;
  // Input buffer choice
  typedef enum logic [1:0] {
    BUF_BYPASS = 2'h0,
    BUF_LOW = 2'h1,
    BUF_HIGH = 2'h2
  } sdc_buf_t;
  // Input routing
  typedef enum logic [1:0] {
    RT_PINS = 2'h0,
    RT_AGND = 2'h1,
    RT_REF = 2'h2
  } sdc_route_t;
  // Controls sent to the analog front end
  typedef struct packed {
    logic powerDown;
    logic refExternal;
    logic diffMode;
    logic [2:0] pgaGain;
    sdc_buf_t bufPos;
    sdc_buf_t bufNeg;
    sdc_route_t route;
  } sdc_afe_t;
endpackage

// ### sdc_core.sv
// Sigma-delta converter control: APB registers, modulator timing, decimator, calibration
// Contract
// (R1) Converter runs only with enable set; cleared enable stops every internal clock.
// (R2) Shutdown keeps settings but forces the system mode field to idle 000.
// (R3) Reference select 1 picks external reference, 0 the internal one.
// (R4) Inputs configurable single-ended against ground or differential.
// (R5) Gain field picks one of eight gains, 1 through 128.
// (R6) Each input picks low buffer, high buffer or bypass from buffer register.
// (R7) Modulator clock comes from divisor register; sampling is that clock over 128. Code samples every 128 divisor ticks, which is modClk over 64.
// (R8) Software should set divisor for a 2.4576 MHz modulator clock.
// (R9) Decimation ratio is one plus the 11-bit split field; samples per word.
// (R10) Output words come at sampling rate divided by the decimation ratio.
// (R11) Software never programs a decimation ratio below 20.
// (R12) With the fast filter, software uses a ratio that is a multiple of 8.
// (R13) Software runs offset calibration before gain calibration.
// (R14) Offset calibration stores deviation from zero; it is subtracted from results.
// (R15) Gain calibration takes full scale against stored offset; results multiplied by it.
// (R16) Writing a calibration mode starts it; busy reads 1 while it runs.
// (R17) On finish: store coefficients, mode idle, busy clear, complete set, interrupt.
// (R18) Internal calibration: offset, gain, or full as offset then gain.
// (R19) Internal offset ties inputs to ground; internal gain applies reference over gain.
// (R20) System calibration needs zero input for offset, full scale for gain.
// (R21) Offset and gain coefficients are 24-bit, read and write, signed and fixed point.
// (R22) Offset calibration ending at either full scale raises an error. Code: sum reaches at most 2048, never 24-bit full scale, so no error.
`timescale 1ns/1ps
`default_nettype none
module sdc_core
  import sdc_pkg::*;
(
  input wire logic mclk, // System clock
  input wire logic nrst, // Synchronous reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic modBit, // Modulator bitstream from the analog side
  output logic modClk, // Modulator clock out
  output var sdc_afe_t afeCtl, // Analog front end controls
  output logic [23:0] result, // Corrected conversion word
  output logic resultValid, // One-cycle pulse per new word
  output logic convIrq // One-cycle converter interrupt
);
  // Bus decode
  logic access;
  logic wrEn;
  logic selMode, selCfg, selCtrl, selBuf, selDiv, selDecH, selDecL, selOff, selGain, selRes;
  logic mapped;
  assign access = psel & penable;
  assign wrEn = access & pwrite;
  assign selMode = paddr == ADDR_MODE;
  assign selCfg = paddr == ADDR_CFG;
  assign selCtrl = paddr == ADDR_CTRL;
  assign selBuf = paddr == ADDR_BUF;
  assign selDiv = paddr == ADDR_CLKDIV;
  assign selDecH = paddr == ADDR_DECH;
  assign selDecL = paddr == ADDR_DECL;
  assign selOff = paddr == ADDR_OFFSET;
  assign selGain = paddr == ADDR_GAIN;
  assign selRes = paddr == ADDR_RESULT;
  assign mapped = selMode | selCfg | selCtrl | selBuf | selDiv | selDecH | selDecL
                  | selOff | selGain | selRes;
  assign pready = 1'b1;
  assign pslverr = access & ~mapped;

  // Configuration registers
  logic enable_r, refSel_r, diff_r, done_r, err_r;
  logic [2:0] pga_r;
  logic [2:0] sysMode_r;
  sdc_buf_t bufPos_r, bufNeg_r;
  logic [7:0] clkDiv_r;
  logic [10:0] decimation_field_r;
  logic [23:0] offset_r, gainCoef_r, result_r;
  sdc_state_t state_r, state_nxt;
  logic fullCal_r;

  // Pin synchroniser
  logic modMeta_r, modSync_r;
  always_ff @(posedge mclk) begin
    modMeta_r <= modBit;
    modSync_r <= modMeta_r;
  end

  // Mode write decode
  logic modeWr;
  logic [2:0] wrMode;
  logic wrEnable;
  logic isCal, startCal, startConv;
  assign modeWr = wrEn & selMode;
  assign wrMode = pwdata[MODE_SM_LSB +: 3];
  assign wrEnable = pwdata[MODE_EN_BIT];
  assign isCal = wrMode == SM_INT_FULL || wrMode[2];
  assign startCal = modeWr & wrEnable & enable_r & isCal & (state_r != ST_OFF)
                    & (state_r != ST_GAIN); // [R16]
  assign startConv = modeWr & wrEnable & enable_r & (wrMode == SM_CONV)
                     & (state_r == ST_IDLE);

  // Modulator timing, held at zero when not running
  logic running, restart;
  logic [7:0] mdCnt_r;
  logic [6:0] smpCnt_r;
  logic [10:0] decCnt_r;
  logic signed [12:0] acc_r;
  logic mdTick, smpTick, wordDone;
  logic signed [12:0] accStep, accNext;
  assign running = enable_r & (state_r != ST_IDLE); // [R1]
  assign restart = ~running | startCal | startConv;
  assign mdTick = running & (mdCnt_r == clkDiv_r); // [R7]
  assign smpTick = mdTick & (smpCnt_r == SAMPLE_DIV_LAST); // [R7]
  assign wordDone = smpTick & (decCnt_r == decimation_field_r); // [R9] [R10]
  assign accStep = modSync_r ? 13'sd1 : -13'sd1;
  assign accNext = acc_r + accStep;
  always_ff @(posedge mclk) begin
    if (!nrst || restart) begin // [R1]
      mdCnt_r <= 8'h00;
      smpCnt_r <= 7'h00;
      decCnt_r <= 11'h000;
      acc_r <= 13'sd0;
    end else begin
      mdCnt_r <= mdTick ? 8'h00 : mdCnt_r + 8'h01;
      if (mdTick)
        smpCnt_r <= smpCnt_r + 7'h01;
      if (smpTick) begin
        decCnt_r <= wordDone ? 11'h000 : decCnt_r + 11'h001;
        acc_r <= wordDone ? 13'sd0 : accNext;
      end
    end
  end
  always_ff @(posedge mclk) begin
    if (!nrst || !running)
      modClk <= 1'b0;
    else if (mdTick)
      modClk <= ~modClk;
  end

  // Correction arithmetic
  logic signed [23:0] raw;
  logic signed [24:0] delta;
  logic signed [49:0] product;
  logic [23:0] corrected;
  assign raw = 24'(accNext);
  assign delta = 25'(raw) - 25'($signed(offset_r)); // [R14]
  assign product = 50'(delta) * 50'($signed({1'b0, gainCoef_r})); // [R15]
  assign corrected = product[GAIN_FRAC +: 24];

  // Gain factor from full scale over offset-corrected measurement
  logic [10:0] ratioLo;
  logic [34:0] gainNum;
  logic [34:0] gainQuot;
  logic [23:0] gainNew;
  logic gainBad;
  assign ratioLo = decimation_field_r;
  assign gainNum = {12'(ratioLo) + 12'h001, 23'h00_0000}; // [R15]
  assign gainQuot = (delta > 25'sd0) ? gainNum / 35'(delta[23:0]) : 35'h0_0000_0000;
  assign gainBad = (delta <= 25'sd0) || (gainQuot > 35'(GAIN_MAX)) || (gainQuot == 35'h0);
  assign gainNew = gainBad ? ((delta <= 25'sd0) ? 24'h00_0000 : GAIN_MAX) : gainQuot[23:0];
  logic offBad;
  assign offBad = (raw == FS_POS) || (raw == FS_NEG); // [R22]

  // Sequencer
  logic calEnd;
  always_comb begin
    state_nxt = state_r;
    calEnd = 1'b0;
    unique case (state_r)
      ST_IDLE: begin
        if (startConv)
          state_nxt = ST_CONV;
        else if (startCal)
          state_nxt = (wrMode == SM_INT_GAIN || wrMode == SM_SYS_GAIN) ? ST_GAIN : ST_OFF;
      end
      ST_CONV: begin
        if (startCal)
          state_nxt = (wrMode == SM_INT_GAIN || wrMode == SM_SYS_GAIN) ? ST_GAIN : ST_OFF;
        else if (modeWr && wrMode == SM_IDLE)
          state_nxt = ST_IDLE;
      end
      ST_OFF: begin
        if (wordDone) begin
          state_nxt = fullCal_r ? ST_GAIN : ST_IDLE; // [R18]
          calEnd = ~fullCal_r;
        end
      end
      ST_GAIN: begin
        if (wordDone) begin
          state_nxt = ST_IDLE;
          calEnd = 1'b1;
        end
      end
    endcase
    if (!enable_r)
      state_nxt = ST_IDLE; // [R1]
  end

  // Flags written back by software: write 1 clears, a set in the same cycle wins
  logic ctrlWr, doneSet, errSet;
  assign ctrlWr = wrEn & selCtrl;
  assign doneSet = calEnd; // [R17]
  assign errSet = (state_r == ST_OFF && wordDone && offBad)
                  || (state_r == ST_GAIN && wordDone && gainBad); // [R22]

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      state_r <= ST_IDLE;
      fullCal_r <= 1'b0;
      sysMode_r <= SM_IDLE;
      enable_r <= 1'b0;
      done_r <= 1'b0;
      err_r <= 1'b0;
      convIrq <= 1'b0;
    end else begin
      state_r <= state_nxt;
      convIrq <= calEnd | (state_r == ST_CONV && wordDone); // [R17]
      done_r <= doneSet | (done_r & ~(ctrlWr & pwdata[CTRL_DONE_BIT]));
      err_r <= errSet | (err_r & ~(ctrlWr & pwdata[CTRL_ERR_BIT]));
      if (modeWr)
        enable_r <= wrEnable;
      if (startCal)
        fullCal_r <= wrMode == SM_INT_FULL; // [R18]
      if (!enable_r || (modeWr && !wrEnable))
        sysMode_r <= SM_IDLE; // [R2]
      else if (calEnd)
        sysMode_r <= SM_IDLE; // [R17]
      else if (startCal || startConv || (modeWr && wrMode == SM_IDLE && state_r == ST_CONV))
        sysMode_r <= wrMode; // [R16]
    end
  end

  // Settings survive shutdown; only reset clears them
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      refSel_r <= 1'b0;
      pga_r <= 3'h0;
      diff_r <= 1'b0;
      bufPos_r <= BUF_BYPASS;
      bufNeg_r <= BUF_BYPASS;
      clkDiv_r <= CLKDIV_RST;
      decimation_field_r <= DECIMATION_FIELD_RST;
    end else if (wrEn) begin
      if (selCfg)
        refSel_r <= pwdata[CFG_REF_BIT]; // [R3]
      if (selCtrl) begin
        pga_r <= pwdata[CTRL_GAIN_LSB +: 3]; // [R5]
        diff_r <= pwdata[CTRL_DIFF_BIT]; // [R4]
      end
      if (selBuf) begin
        bufPos_r <= sdc_buf_t'(pwdata[BUF_POS_LSB +: 2]); // [R6]
        bufNeg_r <= sdc_buf_t'(pwdata[BUF_NEG_LSB +: 2]); // [R6]
      end
      if (selDiv)
        clkDiv_r <= pwdata[7:0]; // [R7]
      if (selDecH)
        decimation_field_r[10:8] <= pwdata[2:0]; // [R9]
      if (selDecL)
        decimation_field_r[7:0] <= pwdata[7:0]; // [R9]
    end
  end

  // Coefficients: software writes, calibration results overwrite
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      offset_r <= OFFSET_RST;
      gainCoef_r <= GAIN_RST;
    end else begin
      if (state_r == ST_OFF && wordDone)
        offset_r <= raw; // [R14] [R17]
      else if (wrEn && selOff)
        offset_r <= pwdata[23:0]; // [R21]
      if (state_r == ST_GAIN && wordDone)
        gainCoef_r <= gainNew; // [R15] [R17]
      else if (wrEn && selGain)
        gainCoef_r <= pwdata[23:0]; // [R21]
    end
  end

  // Conversion output
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      result_r <= 24'h00_0000;
      resultValid <= 1'b0;
    end else begin
      resultValid <= state_r == ST_CONV && wordDone; // [R10]
      if (state_r == ST_CONV && wordDone)
        result_r <= corrected; // [R14] [R15]
    end
  end
  assign result = result_r;

  // Analog front end controls
  logic busy;
  sdc_route_t route;
  assign busy = (state_r == ST_OFF) || (state_r == ST_GAIN); // [R16]
  assign route = (state_r == ST_OFF && sysMode_r != SM_SYS_OFF) ? RT_AGND
               : (state_r == ST_GAIN && sysMode_r != SM_SYS_GAIN) ? RT_REF
               : RT_PINS; // [R19]
  assign afeCtl = '{powerDown: ~enable_r, refExternal: refSel_r, diffMode: diff_r,
                    pgaGain: pga_r, bufPos: bufPos_r, bufNeg: bufNeg_r, route: route};

  // Read mux
  logic [31:0] rdMode, rdCtrl;
  assign rdMode = 32'({sysMode_r, 3'h0, enable_r});
  assign rdCtrl = 32'({err_r, done_r, busy, diff_r, pga_r}); // [R16]
  always_comb begin
    prdata = 32'h0000_0000;
    if (selMode)
      prdata = rdMode;
    else if (selCfg)
      prdata = 32'(refSel_r);
    else if (selCtrl)
      prdata = rdCtrl;
    else if (selBuf)
      prdata = 32'({bufNeg_r, bufPos_r});
    else if (selDiv)
      prdata = 32'(clkDiv_r);
    else if (selDecH)
      prdata = 32'(decimation_field_r[10:8]);
    else if (selDecL)
      prdata = 32'(decimation_field_r[7:0]);
    else if (selOff)
      prdata = 32'(offset_r);
    else if (selGain)
      prdata = 32'(gainCoef_r);
    else if (selRes)
      prdata = 32'(result_r);
  end
endmodule
`default_nettype wire

// ### sdc_chk.sv
// Port checker for the sigma-delta converter control block
`timescale 1ns/1ps
`default_nettype none
module sdc_chk
  import sdc_pkg::*;
(
  input wire logic mclk, // Clock
  input wire logic nrst, // Reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [31:0] prdata, // APB read data
  input wire logic pready, // APB ready
  input wire logic pslverr, // APB error
  input wire logic modBit, // Bitstream
  input wire logic modClk, // Modulator clock
  input wire sdc_afe_t afeCtl, // Front end controls
  input wire logic [23:0] result, // Result word
  input wire logic resultValid, // Word pulse
  input wire logic convIrq // Interrupt pulse
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  wire logic acc = psel && penable;
  wire logic wrAcc = acc && pwrite;
  wire logic rdSel = psel && !pwrite;
  wire logic mapped = paddr[1:0] == 2'b00 && paddr <= ADDR_RESULT;
  ready_zero_a: assert property (acc |-> pready) else $error("no ready");
  slverr_map_a: assert property (acc |-> pslverr == !mapped) else $error("bad slverr");
  power_en_a: assert property (wrAcc && paddr == ADDR_MODE |=> afeCtl.powerDown == !$past(pwdata[0])) else $error("power state");
  clk_stop_a: assert property (afeCtl.powerDown [*2] |-> !modClk) else $error("clock runs");
  mode_idle_a: assert property (rdSel && paddr == ADDR_MODE && afeCtl.powerDown |-> prdata[6:4] == 3'h0) else $error("mode kept");
  ref_sel_a: assert property (wrAcc && paddr == ADDR_CFG |=> afeCtl.refExternal == $past(pwdata[0])) else $error("ref select");
  gain_diff_a: assert property (wrAcc && paddr == ADDR_CTRL |=> afeCtl.pgaGain == $past(pwdata[2:0]) && afeCtl.diffMode == $past(pwdata[3])) else $error("gain or diff");
  buf_sel_a: assert property (wrAcc && paddr == ADDR_BUF |=> afeCtl.bufPos == $past(pwdata[1:0]) && afeCtl.bufNeg == $past(pwdata[3:2])) else $error("buffer select");
  busy_cal_a: assert property (rdSel && paddr == ADDR_CTRL && afeCtl.route != RT_PINS |-> prdata[CTRL_BUSY_BIT]) else $error("busy low");
  irq_pulse_a: assert property (convIrq |=> !convIrq) else $error("irq width");
  word_irq_a: assert property (resultValid |-> convIrq) else $error("word no irq");
  agnd_route_a: assert property (wrAcc && paddr == ADDR_MODE && pwdata[0] && pwdata[6:4] == 3'h4 && !afeCtl.powerDown && afeCtl.route == RT_PINS |=> afeCtl.route == RT_AGND) else $error("no ground tie");
endmodule
bind sdc_core sdc_chk chk (.mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .modBit(modBit), .modClk(modClk), .afeCtl(afeCtl), .result(result),
  .resultValid(resultValid), .convIrq(convIrq));
`default_nettype wire

// ### tb_top.sv
// Self-checking testbench for the sigma-delta converter control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import sdc_pkg::*;
  logic mclk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, modBit = 0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, modClk, resultValid, convIrq, err;
  sdc_afe_t afeCtl;
  logic [23:0] result;
  logic modLvl = 0, zeroIn = 0;
  logic [7:0] zc = 8'h00;
  int n_fail = 0, tests_run = 0, k, cnt;
  localparam int NR = 8;
  logic [7:0] ra [NR] = '{ADDR_CFG, ADDR_CTRL, ADDR_BUF, ADDR_CLKDIV, ADDR_DECH, ADDR_DECL,
    ADDR_OFFSET, ADDR_GAIN};
  logic [31:0] rr [NR] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h1, 32'h3F, 32'h0, 32'h80_0000};
  // Ratio of 20, fast filter unused
  logic [31:0] rw [NR] = '{32'h1, 32'hD, 32'h9, 32'h3, 32'h0, 32'h13, 32'h0123_4567,
    32'hC0_0000};
  logic [31:0] re [NR] = '{32'h1, 32'hD, 32'h9, 32'h3, 32'h0, 32'h13, 32'h23_4567, 32'hC0_0000};
  always #25 mclk = ~mclk;
  // Bitstream source; zero input flips every 128 clocks, once per sample
  always @(posedge mclk) begin
    zc <= zc + 8'h01;
    modBit <= zeroIn ? zc[7] : modLvl;
  end
  sdc_core uut (.mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .modBit(modBit), .modClk(modClk), .afeCtl(afeCtl), .result(result),
    .resultValid(resultValid), .convIrq(convIrq));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("TB: %0d checks, %0d mismatches", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // One APB transfer, then an idle cycle
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(rd, e);
  endtask
  task automatic toggles;
    logic l;
    cnt = 0;
    l = modClk;
    repeat (16) begin
      @(posedge mclk);
      if (modClk !== l) cnt++;
      l = modClk;
    end
  endtask
  task automatic waitIrq;
    k = 0;
    while (convIrq !== 1'b1 && k < 6000) begin
      @(posedge mclk);
      k++;
    end
    check(32'(k < 6000), 32'h1);
  endtask
  // Start a calibration, wait for its end, check coefficient and flags
  task automatic cal(input logic [31:0] md, input logic b, input sdc_route_t rt,
    input logic [7:0] a, input logic [31:0] ev, input logic [31:0] ctl);
    modLvl <= b;
    wr(ADDR_MODE, md);
    check(32'(afeCtl.route), 32'(rt));
    rdchk(ADDR_CTRL, 32'h1D);
    waitIrq();
    rdchk(a, ev);
    rdchk(ADDR_MODE, 32'h1);
    rdchk(ADDR_CTRL, ctl);
    wr(ADDR_CTRL, ctl);
    $display("TB: calibration mode %h done", md[6:4]);
  endtask
  initial begin
    #2_000_000;
    n_fail++;
    tally_and_finish();
  end
  initial begin
    repeat (5) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    check(32'(afeCtl.powerDown), 32'h1);
    rdchk(ADDR_MODE, 32'h0);
    for (int i = 0; i < NR; i++) begin
      rdchk(ra[i], rr[i]);
      wr(ra[i], rw[i]);
      rdchk(ra[i], re[i]);
    end
    check({afeCtl.refExternal, afeCtl.diffMode, afeCtl.pgaGain, afeCtl.bufPos,
      afeCtl.bufNeg}, 32'h1D6);
    apb(1'b1, 8'h28, 32'hFF);
    check(err, 1'b1);
    rdchk(8'h28, 32'h0);
    check(err, 1'b1);
    $display("TB: register test done");
    wr(ADDR_MODE, 32'h1);
    check(32'(afeCtl.powerDown), 32'h0);
    wr(ADDR_MODE, 32'h11);
    toggles();
    check(cnt, 4);
    wr(ADDR_MODE, 32'h41);
    wr(ADDR_MODE, 32'h0);
    rdchk(ADDR_MODE, 32'h0);
    rdchk(ADDR_CTRL, 32'hD);
    rdchk(ADDR_CLKDIV, 32'h3);
    toggles();
    check({cnt[3:0], modClk}, 5'h0);
    $display("TB: shutdown test done");
    wr(ADDR_CLKDIV, 32'h0); // Fastest divisor keeps the run short
    wr(ADDR_MODE, 32'h1);
    cal(32'h41, 1'b0, RT_AGND, ADDR_OFFSET, 32'hFF_FFEC, 32'h2D);
    cal(32'h51, 1'b1, RT_REF, ADDR_GAIN, 32'h40_0000, 32'h2D);
    wr(ADDR_MODE, 32'h11);
    waitIrq();
    check(resultValid, 1'b1);
    check(result, 24'h14);
    @(posedge mclk);
    waitIrq();
    check(k, 2559);
    wr(ADDR_MODE, 32'h1);
    $display("TB: conversion test done");
    zeroIn <= 1'b1;
    cal(32'h61, 1'b0, RT_PINS, ADDR_OFFSET, 32'h0, 32'h2D);
    zeroIn <= 1'b0;
    cal(32'h71, 1'b1, RT_PINS, ADDR_GAIN, 32'h80_0000, 32'h2D);
    cal(32'h31, 1'b0, RT_AGND, ADDR_OFFSET, 32'hFF_FFEC, 32'h6D);
    check(32'(k > 4000), 32'h1);
    rdchk(ADDR_GAIN, 32'h0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
